// ===== hw/conv_pm_pkg.sv
/*
  shared constants for the conversion and power-mode controller:
  timing, address layout, reset values and the controller states.
  assumes a 200 MHz core clock (5 ns period).
*/
package conv_pm_pkg;
  // core clock period and the two documented intervals
  localparam int CLK_NS     = 5;
  localparam int PWRUP_NS   = 4000;  // start-pin power-up interval
  localparam int PERIOD_US  = 400;   // autonomous conversion period
  // least time: round up so the power-up timer never ends early
  localparam int PWRUP_CYC  = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
  // period figure, used as default of the top-level parameter
  localparam int PERIOD_CYC = (PERIOD_US * 1000) / CLK_NS;
  localparam int TMR_W      = 17;    // holds PERIOD_CYC (80000)
  // serial address: fixed upper nibble, user-set low three bits
  localparam logic [3:0] ADDR_HI  = 4'h9;
  localparam int         ADDR_LSB = 3;
  // result value after reset and result width
  localparam int          RES_W   = 10;
  localparam logic [9:0]  RES_RST = 10'h000;
  // controller states, gray along sleep -> powerup -> convert
  typedef enum logic [1:0] {
    ST_SLEEP = 2'h0,
    ST_PWRUP = 2'h1,
    ST_CONV  = 2'h3,
    ST_FAULT = 2'h2
  } state_t;
endpackage

// ===== hw/tmr_if.sv
/*
  carrier between the controller and its down-counting timers.
  assumes both ends share the controller clock.
*/
interface tmr_if #(parameter int W = 17);
  logic         start;  // one-cycle load request
  logic [W-1:0] load;   // cycles until done rises
  logic         done;   // level: count has run out
  modport ctl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface

// ===== hw/cycle_timer.sv
/*
  down-counting interval timer; done rises load cycles after start.
  assumes start is a single-cycle pulse from the same clock domain.
*/
module cycle_timer #(
  parameter int W = 17
) (
  input  wire logic i_clk,
  input  wire logic i_srst,
  tmr_if.tmr        t
);
  logic [W-1:0] cnt_ff;   // cycles still to run
  logic [W-1:0] nxt_cnt;

  // next count: load on start, else count down to zero
  always_comb begin
    nxt_cnt = cnt_ff;
    if (t.start) begin
      nxt_cnt = t.load;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  // register only; reads as expired after reset
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // expiry is a level; no start term, which would loop back via caller
  assign t.done = (cnt_ff == '0);

  // restart always lands on the full load value
  a_timer_load_exact:
  assert property (@(posedge i_clk) disable iff (i_srst)
    t.start |=> (cnt_ff == $past(t.load)))
    else $error("timer did not load its interval");
endmodule

// ===== hw/conv_pm_ctrl.sv
/*
  conversion scheduling and power-mode control of the sensor converter:
  autonomous, shutdown with wake-by-write, start-pin triggered, and the
  stuck state after a failed power-on reset.
  assumes the serial engine (same clock) gives one-cycle strobes for a
  wake write, read start and stop/repeated start, and the converter
  answers each start with a done strobe and its data.
*/
// Behaviour
// - shutdown bit set gives full power-down
// - wake write in shutdown runs one conversion
// - stored result stays readable while powered down
// - overlapping reads keep aborting, results invalid
// - secondary config msb selects pin mode
// - pin mode: only start pin starts conversions
// - pin rising edge starts 4 us power-up
// - long pulse: hold and convert on fall
// - short pulse: convert when 4 us timer ends
// - conversion end with pin low powers down
// - failed reset: no operation, result frozen
// - answer address 1001 plus three user bits
// - autonomous conversion every 400 us
// - read aborts conversion, restarts on stop
module conv_pm_ctrl #(
  parameter int PERIOD_CYC = conv_pm_pkg::PERIOD_CYC
) (
  input  wire logic       I_CLK,
  input  wire logic       I_SRST,
  input  wire logic       I_SHUTDOWN_BIT,
  input  wire logic       I_PIN_MODE,
  input  wire logic       I_CONVERSION_START_PIN,
  input  wire logic [2:0] I_ADDR_SEL,
  input  wire logic [6:0] I_SER_ADDR,
  input  wire logic       I_BUS_WRITE,
  input  wire logic       I_READ_START,
  input  wire logic       I_READ_END,
  input  wire logic       I_POR_FAIL,
  input  wire logic       I_DEFAULTS_LOADED,
  input  wire logic       I_CONV_DONE,
  input  wire logic [9:0] I_CONV_DATA,
  output logic            O_ADDR_MATCH,
  output logic            O_CONV_START,
  output logic            O_CONV_ABORT,
  output logic            O_HOLD,
  output logic            O_POWERED,
  output logic            O_FULL_PD,
  output logic            O_OPERATING,
  output logic            O_RESULT_INVALID,
  output logic [9:0]      O_TEMP_RESULT
);
  // two timers: autonomous period and start-pin power-up
  tmr_if #(.W(conv_pm_pkg::TMR_W)) per_t ();
  tmr_if #(.W(conv_pm_pkg::TMR_W)) pwr_t ();

  cycle_timer #(.W(conv_pm_pkg::TMR_W)) u_per_tmr (
    .i_clk  (I_CLK),
    .i_srst (I_SRST),
    .t      (per_t)
  );
  cycle_timer #(.W(conv_pm_pkg::TMR_W)) u_pwr_tmr (
    .i_clk  (I_CLK),
    .i_srst (I_SRST),
    .t      (pwr_t)
  );

  // pin and address straps come from outside: two flops each
  logic [3:0] sync1_ff;    // first stage, read by sync2_ff only
  logic [3:0] sync2_ff;    // {pin, addr[2:0]} settled
  logic       pin_d_ff;    // settled pin, one cycle older
  logic       pin_s;       // settled start-pin level
  logic       pin_rise;
  logic [2:0] addr_s;

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      pin_d_ff <= 1'b0;
    end else begin
      sync1_ff <= {I_CONVERSION_START_PIN, I_ADDR_SEL};
      sync2_ff <= sync1_ff;
      pin_d_ff <= sync2_ff[3];
    end
  end

  assign pin_s    = sync2_ff[3];
  assign addr_s   = sync2_ff[2:0];
  assign pin_rise = pin_s && !pin_d_ff;
  assign O_ADDR_MATCH =
    (I_SER_ADDR[6:conv_pm_pkg::ADDR_LSB] == conv_pm_pkg::ADDR_HI) &&
    (I_SER_ADDR[2:0] == addr_s);
  // controller state and its side flags
  conv_pm_pkg::state_t st_ff;
  conv_pm_pkg::state_t nxt_st;
  logic       arm_ff;      // first cycle after reset: catch strap
  logic       nxt_arm;
  logic       wake_ff;     // wake write pending in shutdown
  logic       nxt_wake;
  logic       rd_ff;       // read in progress in autonomous mode
  logic       nxt_rd;
  logic       inval_ff;    // last conversion aborted
  logic       nxt_inval;
  logic       start_ff;    // one-cycle converter start
  logic       nxt_start;
  logic       abort_ff;    // one-cycle converter abort
  logic       nxt_abort;
  logic [9:0] res_ff;      // stored result, always readable
  logic [9:0] nxt_res;
  logic       auto_mode;   // periodic conversions enabled
  logic       begin_conv;  // sleep -> convert this cycle
  // mode select: pin mode beats shutdown and periodic
  assign auto_mode = !I_PIN_MODE && !I_SHUTDOWN_BIT;
  // next-state logic for the whole controller
  always_comb begin
    nxt_st    = st_ff;
    nxt_arm   = 1'b0;
    nxt_wake  = wake_ff;
    nxt_rd    = rd_ff;
    nxt_inval = inval_ff;
    nxt_abort = 1'b0;
    nxt_res   = res_ff;
    begin_conv = 1'b0;
    // a wake write is remembered; set wins over the clear below
    if (I_BUS_WRITE && I_SHUTDOWN_BIT && !I_PIN_MODE) begin
      nxt_wake = 1'b1;
    end
    // reads bracket a transfer; restart waits for its stop
    if (I_READ_END) begin
      nxt_rd = 1'b0;
    end
    if (I_READ_START && auto_mode) begin
      nxt_rd = 1'b1;
    end
    case (st_ff)
      conv_pm_pkg::ST_SLEEP: begin
        if (I_PIN_MODE) begin
          // only a pin rise wakes the converter
          if (pin_rise) begin
            nxt_st = conv_pm_pkg::ST_PWRUP;
          end
        end else if (I_SHUTDOWN_BIT) begin
          // full power-down unless a wake is pending
          if (wake_ff) begin
            begin_conv = 1'b1;
          end
        end else if (rd_ff && I_READ_END) begin
          // restart on stop or repeated start
          begin_conv = 1'b1;
        end else if (per_t.done && !rd_ff) begin
          begin_conv = 1'b1;
        end
        if (begin_conv) begin
          nxt_st   = conv_pm_pkg::ST_CONV;
          nxt_wake = I_BUS_WRITE && I_SHUTDOWN_BIT && !I_PIN_MODE;
        end
      end
      conv_pm_pkg::ST_PWRUP: begin
        // hold waits for both timer and pin fall
        if (pwr_t.done && !pin_s) begin
          nxt_st = conv_pm_pkg::ST_CONV;
        end
      end
      conv_pm_pkg::ST_CONV: begin
        if (I_READ_START && auto_mode) begin
          // read aborts; old result is what is read
          nxt_st    = conv_pm_pkg::ST_SLEEP;
          nxt_abort = 1'b1;
          nxt_inval = 1'b1;
        end else if (I_CONV_DONE) begin
          // back to power-down after one result
          nxt_st    = conv_pm_pkg::ST_SLEEP;
          nxt_res   = I_CONV_DATA;
          nxt_inval = 1'b0;
        end
      end
      conv_pm_pkg::ST_FAULT: begin
        // stuck until the defaults are rewritten
        if (I_DEFAULTS_LOADED) begin
          nxt_st = conv_pm_pkg::ST_SLEEP;
        end
      end
      default: begin
        nxt_st = conv_pm_pkg::ST_SLEEP;
      end
    endcase
    // failed power-on reset caught right after release
    if (arm_ff && I_POR_FAIL) begin
      nxt_st = conv_pm_pkg::ST_FAULT;
      nxt_wake = 1'b0;
      nxt_rd = 1'b0;
    end
    nxt_start = (nxt_st == conv_pm_pkg::ST_CONV) &&
                (st_ff != conv_pm_pkg::ST_CONV);
  end

  // register stage for the controller
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      st_ff    <= conv_pm_pkg::ST_SLEEP;
      arm_ff   <= 1'b1;
      wake_ff  <= 1'b0;
      rd_ff    <= 1'b0;
      inval_ff <= 1'b0;
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
      res_ff   <= conv_pm_pkg::RES_RST;
    end else begin
      st_ff    <= nxt_st;
      arm_ff   <= nxt_arm;
      wake_ff  <= nxt_wake;
      rd_ff    <= nxt_rd;
      inval_ff <= nxt_inval;
      start_ff <= nxt_start;
      abort_ff <= nxt_abort;
      res_ff   <= nxt_res;
    end
  end

  // start to start; one cycle of the period goes to restarting
  assign per_t.start = nxt_start;
  assign per_t.load  = conv_pm_pkg::TMR_W'(PERIOD_CYC - 1);
  // power-up interval rounded up to whole cycles
  assign pwr_t.start = (st_ff == conv_pm_pkg::ST_SLEEP) &&
                       (nxt_st == conv_pm_pkg::ST_PWRUP);
  assign pwr_t.load  = conv_pm_pkg::TMR_W'(conv_pm_pkg::PWRUP_CYC);
  // outputs; result is never gated by power state
  // result readable in any mode
  assign O_TEMP_RESULT    = res_ff;
  assign O_RESULT_INVALID = inval_ff;
  assign O_CONV_START     = start_ff;
  assign O_CONV_ABORT     = abort_ff;
  assign O_HOLD           = (st_ff == conv_pm_pkg::ST_CONV);
  assign O_POWERED        = (st_ff == conv_pm_pkg::ST_CONV) ||
                            (st_ff == conv_pm_pkg::ST_PWRUP);
  // full power-down while asleep in shutdown or pin mode; partial otherwise
  assign O_FULL_PD   = (st_ff == conv_pm_pkg::ST_SLEEP) &&
                       (I_SHUTDOWN_BIT || I_PIN_MODE);
  assign O_OPERATING = (st_ff != conv_pm_pkg::ST_FAULT);
  // checks on the controller
  a_shutdown_no_conv:
  assert property (@(posedge I_CLK) disable iff (I_SRST)
    (st_ff == conv_pm_pkg::ST_SLEEP && I_SHUTDOWN_BIT && !I_PIN_MODE
     && !wake_ff && !arm_ff) |=> !O_CONV_START)
    else $error("conversion started in shutdown without wake");

  a_wake_one_conv:
  assert property (@(posedge I_CLK) disable iff (I_SRST)
    (st_ff == conv_pm_pkg::ST_CONV && I_CONV_DONE && I_SHUTDOWN_BIT
     && !I_PIN_MODE && !I_READ_START && !arm_ff)
    |=> O_FULL_PD && !wake_ff)
    else $error("shutdown did not resume after wake conversion");

  a_pin_rise_pwrup:
  assert property (@(posedge I_CLK) disable iff (I_SRST)
    (st_ff == conv_pm_pkg::ST_SLEEP && I_PIN_MODE && pin_rise
     && !arm_ff) |=> O_POWERED && !O_HOLD)
    else $error("pin rise did not start power-up");

  a_pwrup_min_time:
  assert property (@(posedge I_CLK) disable iff (I_SRST)
    pwr_t.start |=> !O_HOLD [*8])
    else $error("hold entered before power-up interval");

  a_pin_high_waits:
  assert property (@(posedge I_CLK) disable iff (I_SRST)
    (st_ff == conv_pm_pkg::ST_PWRUP && pin_s && !arm_ff)
    |=> st_ff != conv_pm_pkg::ST_CONV)
    else $error("conversion began with start pin still high");

  a_pin_end_pd:
  assert property (@(posedge I_CLK) disable iff (I_SRST)
    (st_ff == conv_pm_pkg::ST_CONV && I_CONV_DONE && I_PIN_MODE
     && !pin_s && !arm_ff) |=> O_FULL_PD ##1 !O_CONV_START)
    else $error("no power-down after pin conversion");

  a_fault_frozen:
  assert property (@(posedge I_CLK) disable iff (I_SRST)
    (st_ff == conv_pm_pkg::ST_FAULT) |=> $stable(O_TEMP_RESULT)
    && !O_CONV_START)
    else $error("result moved while stuck after reset");

  a_read_aborts:
  assert property (@(posedge I_CLK) disable iff (I_SRST)
    (st_ff == conv_pm_pkg::ST_CONV && I_READ_START && auto_mode
     && !arm_ff) |=> O_CONV_ABORT && O_RESULT_INVALID
    && $stable(O_TEMP_RESULT))
    else $error("read did not abort conversion");

  a_addr_decode:
  assert property (@(posedge I_CLK) disable iff (I_SRST)
    O_ADDR_MATCH |-> I_SER_ADDR[6:3] == 4'h9)
    else $error("address outside 1001xxx accepted");
endmodule

// ===== tb/ser_master_model.sv
/*
  stand-in for the two-wire bus master: one-cycle transfer strobes.
  assumes the caller sits on a falling edge of the core clock.
*/
module ser_master_model (
  input  wire logic i_clk,
  output logic      o_write,
  output logic      o_rd_start,
  output logic      o_rd_end,
  output logic      o_dflt,
  output logic [6:0] o_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle at time zero
  initial begin
    {o_write, o_rd_start, o_rd_end, o_dflt} = 4'h0;
    o_addr = 7'h48;
  end
  // address presented by the serial engine
  task automatic addr(input logic [6:0] a);
    o_addr = a;
  endtask
  // one strobe at a time, never overlapping a pin pulse
  task automatic pulse(input int sel);
    case (sel)
      0: o_write = 1'b1;
      1: o_rd_start = 1'b1;
      2: o_rd_end = 1'b1;
      default: o_dflt = 1'b1;
    endcase
    @(negedge i_clk);
    // release only the strobe raised, so a following call never
    // touches the same signal twice in one time step
    case (sel)
      0: o_write = 1'b0;
      1: o_rd_start = 1'b0;
      2: o_rd_end = 1'b0;
      default: o_dflt = 1'b0;
    endcase
  endtask
endmodule

// ===== tb/tb_conv_pm_ctrl.sv
/*
  bench for the conversion and power-mode controller.
  assumes the master model beside it; converter is modelled here.
*/
module tb_conv_pm_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PER  = 200;       // shortened period
  localparam int CONV = 20;        // converter busy cycles
  logic       clk   = 1'b0;        // core clock
  logic       srst  = 1'b1;        // sync reset
  logic       sd;                  // shutdown bit
  logic       pmode;               // pin-started mode
  logic       pin;                 // start pin
  logic [2:0] asel;                // address straps
  logic       por;                 // failed power-on strap
  logic       done;                // converter done
  logic [9:0] cdata;               // converter data
  logic       wr, rs, re, dl;      // master strobes
  logic [6:0] saddr;               // master address
  logic       match, start, abort; // dut pulses
  logic       hold, pwr, fpd;      // dut power levels
  logic       oper, inval;         // dut status
  logic [9:0] res;                 // stored result
  logic [9:0] keep;                // saved result
  int         fail_count = 0;
  int         samples_checked = 0;
  int         cnt = 0;             // converter busy count
  int         n;                   // cycle count
  always #2.5 clk = ~clk;
  ser_master_model m (.i_clk(clk), .o_write(wr), .o_rd_start(rs),
    .o_rd_end(re), .o_dflt(dl), .o_addr(saddr));
  conv_pm_ctrl #(.PERIOD_CYC(PER)) DUT (.I_CLK(clk), .I_SRST(srst),
    .I_SHUTDOWN_BIT(sd), .I_PIN_MODE(pmode),
    .I_CONVERSION_START_PIN(pin), .I_ADDR_SEL(asel),
    .I_SER_ADDR(saddr), .I_BUS_WRITE(wr), .I_READ_START(rs),
    .I_READ_END(re), .I_POR_FAIL(por), .I_DEFAULTS_LOADED(dl),
    .I_CONV_DONE(done), .I_CONV_DATA(cdata), .O_ADDR_MATCH(match),
    .O_CONV_START(start), .O_CONV_ABORT(abort), .O_HOLD(hold),
    .O_POWERED(pwr), .O_FULL_PD(fpd), .O_OPERATING(oper),
    .O_RESULT_INVALID(inval), .O_TEMP_RESULT(res));
  // converter: new data and done after CONV cycles in hold;
  // reset reloads its first data word
  always @(negedge clk) begin
    done <= 1'b0;
    if (srst) begin
      cdata <= 10'h005;
      cnt   <= 0;
    end else if (hold !== 1'b1) cnt <= 0;
    else if (cnt == CONV - 1) begin
      done  <= 1'b1;
      cdata <= cdata + 10'h001;
      cnt   <= 0;
    end else cnt <= cnt + 1;
  end
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // falling edges until a start pulse; a spent bound ends the run
  task automatic wait_start(input int lim, output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
      if (k > lim) begin
        fail_count++;
        $display("Error %0t: no conversion start", $time);
        finish_test();
      end
    end while (start !== 1'b1);
  endtask
  task automatic count_starts(input int len, output int k);
    k = 0;
    repeat (len) begin
      @(negedge clk);
      if (start === 1'b1) k++;
    end
  endtask
  task automatic t_auto();
    wait_start(5, n);
    chk(10'(n), 10'h001);
    chk({9'h0, oper}, 10'h001);
    wait_start(PER + 5, n);
    chk(10'(n), 10'(PER));
    $display("test auto done");
  endtask
  // back-to-back reads, each landing inside a conversion
  task automatic t_abort();
    keep = res;
    repeat (2) begin
      chk({9'h0, hold}, 10'h001);
      m.pulse(1);
      chk({9'h0, abort}, 10'h001);
      chk({9'h0, inval}, 10'h001);
      chk(res, keep);
      m.pulse(2);
      chk({9'h0, start}, 10'h001);
    end
    repeat (CONV + 3) @(negedge clk);
    chk({9'h0, inval}, 10'h000);
    chk(res, cdata);
    $display("test abort done");
  endtask
  task automatic t_sd();
    sd = 1'b1;
    repeat (CONV + 5) @(negedge clk);
    chk({9'h0, fpd}, 10'h001);
    count_starts(PER + 20, n);
    chk(10'(n), 10'h000);
    m.pulse(0);
    wait_start(4, n);
    repeat (CONV + 5) @(negedge clk);
    chk(res, cdata);
    chk({9'h0, fpd}, 10'h001);
    m.pulse(1);
    m.pulse(2);
    count_starts(PER + 20, n);
    chk(10'(n), 10'h000);
    chk(res, cdata);
    $display("test shutdown done");
  endtask
  // one pin pulse of hi cycles; start expected within lo..up
  task automatic pin_pulse(input int hi, input int lo, input int up);
    fork
      begin
        pin = 1'b1;
        repeat (hi) @(negedge clk);
        pin = 1'b0;
      end
      wait_start(hi + 900, n);
    join
    chk({9'h0, n >= lo && n <= up}, 10'h001);
    chk({9'h0, pwr}, 10'h001);
    repeat (CONV + 3) @(negedge clk);
    chk({9'h0, fpd}, 10'h001);
    chk({9'h0, pwr}, 10'h000);
    chk(res, cdata);
  endtask
  task automatic t_pin();
    sd = 1'b0;
    pmode = 1'b1;
    m.pulse(0);
    count_starts(PER + 20, n);
    chk(10'(n), 10'h000);
    pin_pulse(32, 801, 807);       // link-rate short pulse
    pin_pulse(1200, 1201, 1208);   // pulse beyond power-up
    $display("test pin done");
  endtask
  task automatic t_addr();
    for (int i = 0; i < 8; i++) begin
      asel = 3'(i);
      m.addr({4'h9, 3'(i)});
      repeat (4) @(negedge clk);
      chk({9'h0, match}, 10'h001);
      m.addr({4'h9, 3'(i + 1)});
      #1;
      chk({9'h0, match}, 10'h000);
      m.addr({4'h8, 3'(i)});
      #1;
      chk({9'h0, match}, 10'h000);
    end
    $display("test address done");
  endtask
  // stuck after failed power-on until defaults come back
  task automatic t_por();
    pmode = 1'b0;
    por = 1'b1;
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    count_starts(PER + 20, n);
    por = 1'b0;
    chk(10'(n), 10'h000);
    chk({9'h0, oper}, 10'h000);
    chk(res, 10'h000);
    m.pulse(3);
    @(negedge clk);
    chk({9'h0, oper}, 10'h001);
    wait_start(PER + 5, n);
    $display("test power-on done");
  endtask
  initial begin
    sd    = 1'b0;
    pmode = 1'b0;
    pin   = 1'b0;
    asel  = 3'h0;
    por   = 1'b0;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    t_auto();
    t_abort();
    t_sd();
    t_pin();
    t_addr();
    t_por();
    finish_test();
  end
endmodule
